// >>> src/nsc_top.sv
// configuration and setup-1 register bank of a token-passing node
// assumes a byte-wide register port, synchronous inputs, one clock
//
// Overview of operation
// - Extended-timeout bits pick response, idle and reconfig timeouts.
// - The two low select bits route the indirect register location.
// - In backplane mode the first pulse output is push-pull if setup bit 7.
// - Excess-nack flag sets after 4 nacks if setup bit 6, else 128.
// - Setup bit 4 accepts every valid packet whatever its destination.
// - In that mode only packets for our own id are acknowledged.
// - Writing the config register clears the top select bit.
`timescale 1ns/1ps
`default_nettype none
module nsc_top (
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_rst_n,
  input  wire logic [3:0]            i_addr,
  input  wire logic [7:0]            i_wdata,
  input  wire logic                  i_wr,
  input  wire logic                  i_rd,
  output logic      [7:0]            o_rdata,
  output logic                       o_irq,
  input  wire logic                  i_tx_req,
  input  wire logic                  i_tx_pulse,
  input  wire logic                  i_nack_seen,
  input  wire logic                  i_nack_clear,
  input  wire nsc_pkg::nsc_rx_hdr_t  i_rx_hdr,
  output nsc_pkg::nsc_rx_dec_t       o_rx_dec,
  output nsc_pkg::nsc_timeouts_t     o_timeouts,
  output logic                       o_first_pulse_out,
  output logic                       o_first_pulse_oe,
  output logic                       o_second_pulse_out_n,
  output logic                       o_tx_driver_enable_n,
  output logic                       o_line_mode_select,
  output logic                       o_excess_nack_flag
);

  logic [7:0] config_q;
  logic [7:0] setup1_q;
  logic       select_top_q;
  logic [7:0] tent_id_q;
  logic [7:0] node_id_q;
  logic [7:0] next_id_q;
  logic [7:0] setup2_q;
  logic [7:0] nack_cnt_q;
  logic       excess_q;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_mask_q;
  logic [7:0] rdata_q;
  logic       pulse_q;
  logic       pulse_oe_q;
  logic       pulse2_n_q;
  logic       transmit_drive_enable_n_q;

  // field views
  wire logic transmit_drive_enable;
  wire logic line_mode_select;
  wire logic [1:0] indirect_reg_select;
  wire logic first_pulse_drive_type;
  wire logic short_nack_limit;
  wire logic promiscuous_receive;
  wire logic [1:0] ext_timeout;

  assign transmit_drive_enable  = config_q[nsc_pkg::CFG_TRANSMIT_DRIVE_ENABLE_BIT];
  assign ext_timeout            = {config_q[nsc_pkg::CFG_ET_HI_BIT],
                                   config_q[nsc_pkg::CFG_ET_LO_BIT]};
  assign line_mode_select       = config_q[nsc_pkg::CFG_LINE_BIT];
  assign indirect_reg_select    = config_q[1:0];
  assign first_pulse_drive_type = setup1_q[nsc_pkg::SU1_FIRST_PULSE_DRIVE_TYPE_BIT];
  assign short_nack_limit       = setup1_q[nsc_pkg::SU1_SHORTNK_BIT];
  assign promiscuous_receive    = setup1_q[nsc_pkg::SU1_PROMISC_BIT];

  // indirect location decode
  function automatic nsc_pkg::nsc_sel_t sel_decode(input logic top, input logic [1:0] low);
    nsc_pkg::nsc_sel_t s;
    s = nsc_pkg::NSC_SEL_RSVD;
    case ({top, low})
      3'b000:  s = nsc_pkg::NSC_SEL_TENT_ID;
      3'b001:  s = nsc_pkg::NSC_SEL_NODE_ID;
      3'b010:  s = nsc_pkg::NSC_SEL_SETUP1;
      3'b011:  s = nsc_pkg::NSC_SEL_NEXT_ID;
      3'b100:  s = nsc_pkg::NSC_SEL_SETUP2;
      default: s = nsc_pkg::NSC_SEL_RSVD;
    endcase
    return s;
  endfunction

  wire nsc_pkg::nsc_sel_t ind_sel;
  assign ind_sel = sel_decode(select_top_q, indirect_reg_select);

  // register port address match, shared by every write strobe
  function automatic logic addr_is(input logic [3:0] addr, input logic [3:0] offset);
    return addr == offset;
  endfunction

  // write strobes
  wire logic wr_config;
  wire logic wr_setup1;
  wire logic wr_subaddr;
  wire logic wr_ind;
  wire logic wr_node_id;
  wire logic wr_tent_id;
  wire logic wr_setup2;
  wire logic wr_irq_stat;
  wire logic wr_irq_mask;

  assign wr_config   = i_wr & addr_is(i_addr, nsc_pkg::OFF_CONFIG);
  assign wr_subaddr  = i_wr & addr_is(i_addr, nsc_pkg::OFF_SUBADDR);
  assign wr_ind      = i_wr & addr_is(i_addr, nsc_pkg::OFF_INDIRECT);
  assign wr_setup1   = (i_wr & addr_is(i_addr, nsc_pkg::OFF_SETUP1))
                     | (wr_ind & (ind_sel == nsc_pkg::NSC_SEL_SETUP1));
  assign wr_node_id  = (i_wr & addr_is(i_addr, nsc_pkg::OFF_NODE_ID))
                     | (wr_ind & (ind_sel == nsc_pkg::NSC_SEL_NODE_ID));
  // next id has no write path: read-only through the indirect location
  assign wr_tent_id  = wr_ind & (ind_sel == nsc_pkg::NSC_SEL_TENT_ID);
  assign wr_setup2   = wr_ind & (ind_sel == nsc_pkg::NSC_SEL_SETUP2);
  assign wr_irq_stat = i_wr & addr_is(i_addr, nsc_pkg::OFF_IRQ_STAT);
  assign wr_irq_mask = i_wr & addr_is(i_addr, nsc_pkg::OFF_IRQ_MASK);

  // low select bits are one store shared by config and sub-address views
  wire logic [7:0] config_d;
  assign config_d = wr_config  ? i_wdata :
                    wr_subaddr ? {config_q[7:2], i_wdata[1:0]} : config_q;

  // the sub-address write loads the top bit from data bit 2; a config write drops it
  wire logic select_top_d;
  assign select_top_d = wr_config  ? 1'b0 :
                        wr_subaddr ? i_wdata[2] : select_top_q;

  // one short process per register keeps each write path easy to follow
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      config_q <= nsc_pkg::CONFIG_RESET;
    end else begin
      config_q <= config_d;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      select_top_q <= 1'b0;
    end else begin
      select_top_q <= select_top_d;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      setup1_q <= nsc_pkg::SETUP1_RESET;
    end else if (wr_setup1) begin
      setup1_q <= i_wdata;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      node_id_q <= nsc_pkg::IDENT_RESET;
    end else if (wr_node_id) begin
      node_id_q <= i_wdata;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tent_id_q <= nsc_pkg::IDENT_RESET;
    end else if (wr_tent_id) begin
      tent_id_q <= i_wdata;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      setup2_q <= nsc_pkg::IDENT_RESET;
    end else if (wr_setup2) begin
      setup2_q <= i_wdata;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_mask_q <= 2'h0;
    end else if (wr_irq_mask) begin
      irq_mask_q <= i_wdata[1:0];
    end
  end

  // next id is read-only here; follows tentative id as a simple stand-in
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      next_id_q <= nsc_pkg::IDENT_RESET;
    end else begin
      next_id_q <= tent_id_q;
    end
  end

  // timeouts
  nsc_timeout_sel u_timeout_sel (
    .i_ext_bits (ext_timeout),
    .o_timeouts (o_timeouts)
  );

  // receive filter
  nsc_rx_filter u_rx_filter (
    .i_promisc (promiscuous_receive),
    .i_node_id (node_id_q),
    .i_hdr     (i_rx_hdr),
    .o_dec     (o_rx_dec)
  );

  // excessive nack counting
  wire logic [7:0] nack_limit;
  wire logic       nack_hit;
  assign nack_limit = short_nack_limit ? nsc_pkg::NACK_LIMIT_SHORT
                                       : nsc_pkg::NACK_LIMIT_LONG;
  assign nack_hit   = i_nack_seen & ((nack_cnt_q + 8'h01) >= nack_limit);

  // count restarts after every hit, so the limit applies again
  wire logic [7:0] nack_cnt_d;
  assign nack_cnt_d = (nack_hit | i_nack_clear) ? 8'h00 :
                      i_nack_seen               ? nack_cnt_q + 8'h01 : nack_cnt_q;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      nack_cnt_q <= 8'h00;
    end else begin
      nack_cnt_q <= nack_cnt_d;
    end
  end

  // a new hit wins over a clear in the same cycle
  wire logic excess_d;
  assign excess_d = nack_hit | (excess_q & ~i_nack_clear);

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      excess_q <= 1'b0;
    end else begin
      excess_q <= excess_d;
    end
  end

  // interrupts: status set wins over write-one-to-clear
  wire logic [1:0] irq_events;
  assign irq_events[nsc_pkg::IRQ_EXCESS_NACK_FLAG_BIT] = nack_hit;
  assign irq_events[nsc_pkg::IRQ_RXPKT_BIT]  = o_rx_dec.accept;

  wire logic [1:0] irq_clear;
  wire logic [1:0] irq_stat_d;
  assign irq_clear  = wr_irq_stat ? i_wdata[1:0] : 2'h0;
  assign irq_stat_d = (irq_stat_q & ~irq_clear) | irq_events;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_stat_q <= 2'h0;
    end else begin
      irq_stat_q <= irq_stat_d;
    end
  end

  assign o_irq = |(irq_stat_q & irq_mask_q);

  // pulse line drivers, registered
  wire logic tx_active;
  assign tx_active = transmit_drive_enable & i_tx_req;

  // open drain: pull low on a pulse, otherwise let go
  wire logic open_drain;
  wire logic pulse_d;
  wire logic pulse_oe_d;
  assign open_drain = line_mode_select & ~first_pulse_drive_type;
  assign pulse_d    = tx_active & ~open_drain & i_tx_pulse;
  assign pulse_oe_d = tx_active & (open_drain ? i_tx_pulse : 1'b1);

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      transmit_drive_enable_n_q   <= 1'b1;
      pulse2_n_q <= 1'b1;
    end else begin
      transmit_drive_enable_n_q   <= ~(tx_active & line_mode_select);
      pulse2_n_q <= ~(tx_active & ~line_mode_select & i_tx_pulse);
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pulse_q    <= 1'b0;
      pulse_oe_q <= 1'b0;
    end else begin
      pulse_q    <= pulse_d;
      pulse_oe_q <= pulse_oe_d;
    end
  end

  assign o_first_pulse_out    = pulse_q;
  assign o_first_pulse_oe     = pulse_oe_q;
  assign o_second_pulse_out_n = pulse2_n_q;
  assign o_tx_driver_enable_n = transmit_drive_enable_n_q;
  assign o_line_mode_select   = line_mode_select;
  assign o_excess_nack_flag   = excess_q;

  // read mux
  wire logic [7:0] ind_rdata;
  assign ind_rdata = (ind_sel == nsc_pkg::NSC_SEL_TENT_ID) ? tent_id_q :
                     (ind_sel == nsc_pkg::NSC_SEL_NODE_ID) ? node_id_q :
                     (ind_sel == nsc_pkg::NSC_SEL_SETUP1)  ? setup1_q  :
                     (ind_sel == nsc_pkg::NSC_SEL_NEXT_ID) ? next_id_q :
                     (ind_sel == nsc_pkg::NSC_SEL_SETUP2)  ? setup2_q  : 8'h00;

  logic [7:0] rd_mux;
  always_comb begin
    case (i_addr)
      nsc_pkg::OFF_CONFIG:   rd_mux = config_q;
      nsc_pkg::OFF_SETUP1:   rd_mux = setup1_q;
      nsc_pkg::OFF_SUBADDR:  rd_mux = {5'h00, select_top_q, config_q[1:0]};
      nsc_pkg::OFF_INDIRECT: rd_mux = ind_rdata;
      nsc_pkg::OFF_NODE_ID:  rd_mux = node_id_q;
      nsc_pkg::OFF_IRQ_STAT: rd_mux = {6'h00, irq_stat_q};
      nsc_pkg::OFF_IRQ_MASK: rd_mux = {6'h00, irq_mask_q};
      nsc_pkg::OFF_TIMEOUT:  rd_mux = {5'h00, excess_q, ext_timeout};
      default:               rd_mux = 8'h00;
    endcase
  end

  // reads return zero outside the one answer cycle
  wire logic [7:0] rdata_d;
  assign rdata_d = i_rd ? rd_mux : 8'h00;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign o_rdata = rdata_q;

endmodule
`default_nettype wire

// >>> src/nsc_pkg.sv
// package for the node setup/config register bank
// assumes a single 100 MHz system clock domain
package nsc_pkg;

  localparam int unsigned CLK_MHZ = 100;

  // register offsets (plain port, byte wide data)
  localparam logic [3:0] OFF_CONFIG   = 4'h0;
  localparam logic [3:0] OFF_SETUP1   = 4'h1;
  localparam logic [3:0] OFF_SUBADDR  = 4'h2;
  localparam logic [3:0] OFF_INDIRECT = 4'h3;
  localparam logic [3:0] OFF_NODE_ID  = 4'h4;
  localparam logic [3:0] OFF_IRQ_STAT = 4'h5;
  localparam logic [3:0] OFF_IRQ_MASK = 4'h6;
  localparam logic [3:0] OFF_TIMEOUT  = 4'h7;

  // configuration register fields
  localparam int unsigned CFG_TRANSMIT_DRIVE_ENABLE_BIT  = 5;
  localparam int unsigned CFG_ET_HI_BIT = 4;
  localparam int unsigned CFG_ET_LO_BIT = 3;
  localparam int unsigned CFG_LINE_BIT  = 2;
  // setup 1 fields
  localparam int unsigned SU1_FIRST_PULSE_DRIVE_TYPE_BIT  = 7;
  localparam int unsigned SU1_SHORTNK_BIT = 6;
  localparam int unsigned SU1_PROMISC_BIT = 4;

  localparam logic [7:0] CONFIG_RESET  = 8'h00;
  localparam logic [7:0] SETUP1_RESET  = 8'h00;
  localparam logic [7:0] IDENT_RESET   = 8'h00;

  // nack limits
  localparam logic [7:0] NACK_LIMIT_SHORT = 8'h04;
  localparam logic [7:0] NACK_LIMIT_LONG  = 8'h80;

  // timeouts, as printed: response in tenths of us, idle in us, reconfig in ms
  localparam int unsigned RESP_00_TUS = 5966;
  localparam int unsigned RESP_01_TUS = 2984;
  localparam int unsigned RESP_10_TUS = 1492;
  localparam int unsigned RESP_11_TUS = 374;
  localparam int unsigned IDLE_00_US  = 656;
  localparam int unsigned IDLE_01_US  = 328;
  localparam int unsigned IDLE_10_US  = 164;
  localparam int unsigned IDLE_11_US  = 41;
  localparam int unsigned RCFG_LONG_MS  = 840;
  localparam int unsigned RCFG_SHORT_MS = 420;

  // cycle counts (longest times, so rounded down)
  localparam logic [31:0] RESP_00_CYC = 32'(RESP_00_TUS * CLK_MHZ / 10);
  localparam logic [31:0] RESP_01_CYC = 32'(RESP_01_TUS * CLK_MHZ / 10);
  localparam logic [31:0] RESP_10_CYC = 32'(RESP_10_TUS * CLK_MHZ / 10);
  localparam logic [31:0] RESP_11_CYC = 32'(RESP_11_TUS * CLK_MHZ / 10);
  localparam logic [31:0] IDLE_00_CYC = 32'(IDLE_00_US * CLK_MHZ);
  localparam logic [31:0] IDLE_01_CYC = 32'(IDLE_01_US * CLK_MHZ);
  localparam logic [31:0] IDLE_10_CYC = 32'(IDLE_10_US * CLK_MHZ);
  localparam logic [31:0] IDLE_11_CYC = 32'(IDLE_11_US * CLK_MHZ);
  localparam logic [31:0] RCFG_LONG_CYC  = 32'(RCFG_LONG_MS * 1000 * CLK_MHZ);
  localparam logic [31:0] RCFG_SHORT_CYC = 32'(RCFG_SHORT_MS * 1000 * CLK_MHZ);

  // interrupt status bits
  localparam int unsigned IRQ_EXCESS_NACK_FLAG_BIT = 0;
  localparam int unsigned IRQ_RXPKT_BIT  = 1;

  typedef enum logic [2:0] {
    NSC_SEL_TENT_ID,
    NSC_SEL_NODE_ID,
    NSC_SEL_SETUP1,
    NSC_SEL_NEXT_ID,
    NSC_SEL_SETUP2,
    NSC_SEL_RSVD
  } nsc_sel_t;

  typedef struct packed {
    logic [31:0] response;
    logic [31:0] idle;
    logic [31:0] reconfig;
  } nsc_timeouts_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] dest_id;
  } nsc_rx_hdr_t;

  typedef struct packed {
    logic accept;
    logic send_ack;
  } nsc_rx_dec_t;

endpackage

// >>> src/nsc_timeout_sel.sv
// timeout selection from the two extended-timeout bits
// assumes the counters that use these values live elsewhere in the node
`timescale 1ns/1ps
`default_nettype none
module nsc_timeout_sel (
  input  wire logic [1:0]            i_ext_bits,
  output nsc_pkg::nsc_timeouts_t     o_timeouts
);

  always_comb begin
    case (i_ext_bits)
      2'b00: begin
        o_timeouts = '{nsc_pkg::RESP_00_CYC, nsc_pkg::IDLE_00_CYC, nsc_pkg::RCFG_LONG_CYC};
      end
      2'b01: begin
        o_timeouts = '{nsc_pkg::RESP_01_CYC, nsc_pkg::IDLE_01_CYC, nsc_pkg::RCFG_LONG_CYC};
      end
      2'b10: begin
        o_timeouts = '{nsc_pkg::RESP_10_CYC, nsc_pkg::IDLE_10_CYC, nsc_pkg::RCFG_LONG_CYC};
      end
      default: begin
        o_timeouts = '{nsc_pkg::RESP_11_CYC, nsc_pkg::IDLE_11_CYC, nsc_pkg::RCFG_SHORT_CYC};
      end
    endcase
  end

endmodule
`default_nettype wire

// >>> src/nsc_rx_filter.sv
// receive address filter with promiscuous mode
// assumes the header is presented for one cycle per valid data packet
`timescale 1ns/1ps
`default_nettype none
module nsc_rx_filter (
  input  wire logic                  i_promisc,
  input  wire logic [7:0]            i_node_id,
  input  wire nsc_pkg::nsc_rx_hdr_t  i_hdr,
  output nsc_pkg::nsc_rx_dec_t       o_dec
);

  wire logic own_dest;
  assign own_dest = i_hdr.dest_id == i_node_id;

  // acks stay tied to own id even when listening to everything
  assign o_dec.accept   = i_hdr.valid & (own_dest | i_promisc);
  assign o_dec.send_ack = i_hdr.valid & own_dest;

endmodule
`default_nettype wire

// >>> verification/nsc_net_model.sv
// model of the other nodes on the network: packet headers and nack pulses
// assumes one clock; headers are driven just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module nsc_net_model (
  input  wire logic            i_clk_sys,
  output nsc_pkg::nsc_rx_hdr_t o_rx_hdr,
  output logic                 o_nack_seen
);
  initial begin
    o_rx_hdr = '0;
    o_nack_seen = 1'b0;
  end
  task automatic pkt(input logic [7:0] dest);
    @(posedge i_clk_sys);
    o_rx_hdr <= {1'b1, dest};
  endtask
  // id lines flip between frames so a stale id can never look valid
  task automatic quiet();
    @(posedge i_clk_sys);
    o_rx_hdr <= {1'b0, ~o_rx_hdr.dest_id};
  endtask
  task automatic nacks(input int n);
    repeat (n) begin
      @(posedge i_clk_sys);
      o_nack_seen <= 1'b1;
      @(posedge i_clk_sys);
      o_nack_seen <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// >>> verification/nsc_top_sva.sv
// checker for the node setup/config register bank
// assumes it is bound to nsc_top and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module nsc_top_sva (
  input wire logic                   i_clk_sys,
  input wire logic                   i_rst_n,
  input wire logic                   i_tx_req,
  input wire logic                   i_tx_pulse,
  input wire logic                   i_nack_seen,
  input wire logic                   i_nack_clear,
  input wire nsc_pkg::nsc_rx_hdr_t   i_rx_hdr,
  input wire nsc_pkg::nsc_rx_dec_t   o_rx_dec,
  input wire nsc_pkg::nsc_timeouts_t o_timeouts,
  input wire logic                   o_first_pulse_out,
  input wire logic                   o_second_pulse_out_n,
  input wire logic                   o_tx_driver_enable_n,
  input wire logic                   o_line_mode_select,
  input wire logic                   o_excess_nack_flag
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  sequence s_tx_idle;
    o_tx_driver_enable_n && o_second_pulse_out_n && !o_first_pulse_out;
  endsequence
  a_timeout_slow: assert property (o_timeouts.response == nsc_pkg::RESP_00_CYC |->
    o_timeouts.idle == nsc_pkg::IDLE_00_CYC && o_timeouts.reconfig == nsc_pkg::RCFG_LONG_CYC)
    else $error("slow timeout row mixed up");
  a_timeout_fast: assert property (o_timeouts.response == nsc_pkg::RESP_11_CYC |->
    o_timeouts.idle == nsc_pkg::IDLE_11_CYC && o_timeouts.reconfig == nsc_pkg::RCFG_SHORT_CYC)
    else $error("fast timeout row mixed up");
  a_normal_line_drv: assert property (!$past(o_line_mode_select) |-> o_tx_driver_enable_n)
    else $error("driver enable active in normal line mode");
  a_open_drain_low: assert property ($past(o_line_mode_select) && !$past(i_tx_pulse)
    |-> !o_first_pulse_out) else $error("first pulse driven high without pulse");
  a_flag_from_nack: assert property ($rose(o_excess_nack_flag) |-> $past(i_nack_seen))
    else $error("excess nack flag set without a nack");
  a_flag_sticky: assert property (o_excess_nack_flag && !i_nack_clear |=> o_excess_nack_flag)
    else $error("excess nack flag dropped on its own");
  a_accept_valid: assert property (o_rx_dec.accept |-> i_rx_hdr.valid)
    else $error("packet accepted without a valid header");
  a_ack_subset: assert property (o_rx_dec.send_ack |-> o_rx_dec.accept && i_rx_hdr.valid)
    else $error("ack sent for a packet not accepted");
  a_tx_gate_idle: assert property (!$past(i_tx_req) |-> s_tx_idle)
    else $error("transmit outputs active without request");
endmodule
bind nsc_top nsc_top_sva i_sva (.i_clk_sys, .i_rst_n, .i_tx_req, .i_tx_pulse, .i_nack_seen,
  .i_nack_clear, .i_rx_hdr, .o_rx_dec, .o_timeouts, .o_first_pulse_out, .o_second_pulse_out_n,
  .o_tx_driver_enable_n, .o_line_mode_select, .o_excess_nack_flag);
`default_nettype wire

// >>> verification/tb_nsc_top.sv
// self-checking bench for the node setup/config register bank
// assumes the net model drives headers and nacks; bench is the host
`timescale 1ns/1ps
`default_nettype none
module tb_nsc_top;
  logic                   clk = 0, rst_n = 0, wr = 0, rd = 0, nclr = 0, req = 0, pls = 0;
  logic [3:0]             addr = '0;
  logic [7:0]             wdata = '0, rdata, d, dest;
  logic                   irq, p1o, p1oe, p2n, transmit_drive_enable_n, line, flag, nack;
  nsc_pkg::nsc_rx_hdr_t   hdr;
  nsc_pkg::nsc_rx_dec_t   dec;
  nsc_pkg::nsc_timeouts_t tmo;
  int                     num_errors = 0, samples_checked = 0, r;
  always #5 clk = ~clk;
  nsc_net_model i_net (.i_clk_sys(clk), .o_rx_hdr(hdr), .o_nack_seen(nack));
  nsc_top i_dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .o_irq(irq), .i_tx_req(req), .i_tx_pulse(pls),
    .i_nack_seen(nack), .i_nack_clear(nclr), .i_rx_hdr(hdr), .o_rx_dec(dec), .o_timeouts(tmo),
    .o_first_pulse_out(p1o), .o_first_pulse_oe(p1oe), .o_second_pulse_out_n(p2n),
    .o_tx_driver_enable_n(transmit_drive_enable_n), .o_line_mode_select(line), .o_excess_nack_flag(flag));
  function automatic logic [95:0] exp_to(input logic [1:0] p);
    case (p)
      2'b00: return {nsc_pkg::RESP_00_CYC, nsc_pkg::IDLE_00_CYC, nsc_pkg::RCFG_LONG_CYC};
      2'b01: return {nsc_pkg::RESP_01_CYC, nsc_pkg::IDLE_01_CYC, nsc_pkg::RCFG_LONG_CYC};
      2'b10: return {nsc_pkg::RESP_10_CYC, nsc_pkg::IDLE_10_CYC, nsc_pkg::RCFG_LONG_CYC};
      default: return {nsc_pkg::RESP_11_CYC, nsc_pkg::IDLE_11_CYC, nsc_pkg::RCFG_SHORT_CYC};
    endcase
  endfunction
  // {out, oe, second_n, enable_n} one cycle after the inputs
  function automatic logic [3:0] exp_tx(input logic [2:0] k, input logic q, input logic p);
    logic a;
    a = k[2] & q;
    if (!k[1]) return {a & p, a, ~(a & p), 1'b1};
    return {a & p & k[0], k[0] ? a : a & p, 1'b1, ~a};
  endfunction
  task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, e);
  endtask
  task automatic clear_flag();
    @(posedge clk);
    nclr <= 1'b1;
    @(posedge clk);
    nclr <= 1'b0;
    @(negedge clk);
    chk(flag, 0);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #200_000;
    num_errors++;
    tally_and_finish();
  end
  initial begin
    r = $urandom(29);
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(nsc_pkg::OFF_CONFIG, 8'h00);
    rd_chk(nsc_pkg::OFF_SETUP1, 8'h00);
    for (int p = 0; p < 4; p++) begin
      wreg(nsc_pkg::OFF_CONFIG, 8'(p << 3));
      @(negedge clk);
      chk(tmo, exp_to(2'(p)));
      rd_chk(nsc_pkg::OFF_TIMEOUT, 8'(p));
    end
    $display("test timeouts done");
    d = 8'($urandom);
    wreg(nsc_pkg::OFF_CONFIG, 8'h01);
    wreg(nsc_pkg::OFF_INDIRECT, d);
    rd_chk(nsc_pkg::OFF_NODE_ID, d);
    wreg(nsc_pkg::OFF_CONFIG, 8'h02);
    wreg(nsc_pkg::OFF_INDIRECT, 8'h50);
    rd_chk(nsc_pkg::OFF_SETUP1, 8'h50);
    wreg(nsc_pkg::OFF_CONFIG, 8'h00);
    wreg(nsc_pkg::OFF_INDIRECT, ~d);
    rd_chk(nsc_pkg::OFF_INDIRECT, ~d);
    wreg(nsc_pkg::OFF_SUBADDR, 8'h04);
    rd_chk(nsc_pkg::OFF_SUBADDR, 8'h04);
    wreg(nsc_pkg::OFF_INDIRECT, 8'h5a);
    rd_chk(nsc_pkg::OFF_INDIRECT, 8'h5a);
    wreg(nsc_pkg::OFF_CONFIG, 8'h03);
    rd_chk(nsc_pkg::OFF_SUBADDR, 8'h03);
    rd_chk(nsc_pkg::OFF_INDIRECT, ~d);
    wreg(4'h9, 8'hff);
    rd_chk(4'h9, 8'h00);
    $display("test select done");
    // short limit is armed by the 0x50 setup value; mask is still off
    i_net.nacks(3);
    @(negedge clk);
    chk(flag, 0);
    i_net.nacks(1);
    @(negedge clk);
    chk({flag, irq}, 2'b10);
    wreg(nsc_pkg::OFF_IRQ_MASK, 8'h01);
    @(negedge clk);
    chk(irq, 1);
    wreg(nsc_pkg::OFF_IRQ_STAT, 8'h03);
    @(negedge clk);
    chk(irq, 0);
    clear_flag();
    wreg(nsc_pkg::OFF_SETUP1, 8'h10);
    i_net.nacks(127);
    @(negedge clk);
    chk(flag, 0);
    i_net.nacks(1);
    rd_chk(nsc_pkg::OFF_TIMEOUT, 8'h04);
    clear_flag();
    $display("test nack limit done");
    for (int m = 0; m < 2; m++) begin
      wreg(nsc_pkg::OFF_SETUP1, m ? 8'h10 : 8'h00);
      repeat (20) begin
        dest = ($urandom % 3 == 0) ? d : 8'($urandom);
        i_net.pkt(dest);
        @(negedge clk);
        chk(dec, {dest == d || m == 1, dest == d});
      end
      i_net.quiet();
      @(negedge clk);
      chk(dec, 2'b00);
    end
    $display("test receive filter done");
    for (int k = 0; k < 8; k++) begin
      wreg(nsc_pkg::OFF_SETUP1, {k[0], 7'h00});
      wreg(nsc_pkg::OFF_CONFIG, {2'b00, k[2], 2'b00, k[1], 2'b00});
      repeat (4) begin
        @(posedge clk);
        req <= 1'($urandom);
        pls <= 1'($urandom);
        @(posedge clk);
        @(negedge clk);
        chk({p1o, p1oe, p2n, transmit_drive_enable_n}, exp_tx(3'(k), req, pls));
        chk(line, k[1]);
      end
    end
    $display("test transmit drive done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
